// [hdl/ams_pkg.sv]
/*
  Shared definitions for the converter slot sequencer: register addresses,
  field positions, reset values, timing figures, state and carrier types.
  Assumes byte-wide configuration registers on a 16-bit address space.
*/
package ams_pkg;

  // ----------------------------------------------------------------------
  // Register addresses and their storage indexes
  // ----------------------------------------------------------------------
  localparam logic [15:0] AMS_ADDR_FRAME_S10 = 16'h2100; // Count, slot 10
  localparam logic [15:0] AMS_ADDR_S8_S9     = 16'h2101; // Slots 8 and 9
  localparam logic [15:0] AMS_ADDR_S6_S7     = 16'h2102; // Slots 6 and 7
  localparam logic [15:0] AMS_ADDR_S4_S5     = 16'h2103; // Slots 4 and 5
  localparam logic [15:0] AMS_ADDR_S2_S3     = 16'h2104; // Slots 2 and 3
  localparam logic [15:0] AMS_ADDR_S0_S1     = 16'h2105; // Slots 0 and 1
  localparam logic [15:0] AMS_ADDR_EQU_CHOP  = 16'h2106; // Equation, chop
  localparam logic [15:0] AMS_ADDR_FILT_DIFF = 16'h210c; // Filter, diff
  localparam logic [15:0] AMS_ADDR_CONV_CLK  = 16'h2200; // Converter clock
  localparam logic [15:0] AMS_ADDR_PREAMP    = 16'h2704; // Preamp gain
  localparam logic [15:0] AMS_ADDR_REMOTE    = 16'h2709; // Remote sensors
  localparam int          AMS_NUM_REGS       = 11;       // Stored bytes
  localparam logic [3:0]  AMS_IDX_NONE       = 4'hf;     // Unmapped
  localparam logic [3:0]  AMS_IDX_EQU_CHOP   = 4'h6;
  localparam logic [3:0]  AMS_IDX_FILT_DIFF  = 4'h7;
  localparam logic [3:0]  AMS_IDX_CONV_CLK   = 4'h8;
  localparam logic [3:0]  AMS_IDX_PREAMP     = 4'h9;
  localparam logic [3:0]  AMS_IDX_REMOTE     = 4'ha;
  localparam logic [7:0]  AMS_REG_RESET      = 8'h00;    // Every register

  // ----------------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------------
  localparam int AMS_FRAME_CNT_LSB = 4; // Frame slot count [7:4]
  localparam int AMS_EQU_LSB       = 5; // Metering equation [7:5]
  localparam int AMS_CHOP_LSB      = 2; // Reference chop control [3:2]
  localparam int AMS_FILT_LSB      = 1; // Filter length [2:1]
  localparam int AMS_DIFF_LSB      = 4; // Differential enables [7:4]
  localparam int AMS_ADC_DIV_BIT   = 5; // Converter rate divide
  localparam int AMS_PLL_FAST_BIT  = 4; // Fast PLL
  localparam int AMS_PREAMP_BIT    = 5; // Preamp gain enable
  localparam int AMS_REMOTE_LSB    = 3; // Remote enables [5:3]

  // ----------------------------------------------------------------------
  // Slot limit, frame overheads in timebase cycles, and chop codes
  // ----------------------------------------------------------------------
  localparam logic [3:0] AMS_MAX_SLOTS   = 4'd11; // Slots in a frame
  localparam logic [4:0] AMS_PRE_FAST    = 5'd1;  // Frame overhead, fast
  localparam logic [4:0] AMS_PRE_SLOW    = 5'd3;  // Frame overhead, slow
  localparam logic [1:0] AMS_CHOP_HIGH   = 2'b01; // Swap held high
  localparam logic [1:0] AMS_CHOP_LOW    = 2'b10; // Swap held low

  // ----------------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------------
  typedef enum logic [1:0] {
    AMS_IDLE = 2'b00, // Frame slot count is zero
    AMS_PRE  = 2'b01, // Frame overhead before slot 0
    AMS_SLOT = 2'b10  // Converting a slot
  } ams_state_e;

  typedef struct packed {
    logic [3:0] slot;         // Current slot number
    logic [3:0] handle;       // Input handle steering the multiplexer
    logic       filterStart;  // Pulse: filter pass begins
    logic       refSwap;      // Reference swap signal level
    logic       ceStart;      // Pulse: compute-engine pass begins
    logic       remoteStrobe; // Pulse: remote sensors sampled
    logic       active;       // Frames are running
  } ams_seq_s;

  typedef struct packed {
    logic [3:0] diffEn;      // Effective differential enables
    logic [2:0] remoteEn;    // Remote sensor enables, phases A to C
    logic       preampGain8; // Neutral pair gain of eight
    logic [2:0] equation;    // Metering equation select
  } ams_cfg_s;

endpackage

// [hdl/ams_slot_sequencer.sv]
/*
  Slot sequencer of the metering front end: configuration registers on
  the byte-wide configuration port, timebase edge detection and the frame
  state machine that steps the input multiplexer.
  Assumes the timebase arrives asynchronous to mclk and is far slower.
*/
// Notes on behaviour
// - Differential enable ignored on remote current channels.
// - Preamp enable clear gives neutral unity gain.
// - Remote samples taken in frame's second half.
// - Shunt setup frame lasts 13 timebase cycles.
// - Transformer setup frame lasts 15 timebase cycles.
// - Sequencer steps mux, starts filter, swaps reference.
// - Sequencer launches each compute-engine pass.
// - Each frame and slot starts on a timebase rising edge.
// - Chop, count, filter and divide fields govern.
// - Slot lasts as long as filter length needs.
// - Frame starts at slot 0, runs count slots.
// - Slot select chooses input handle per slot.
// - Slot duration product, tripled without fast PLL.
// - All configuration registers reset to zero.
`timescale 1ns/1ns

module ams_slot_sequencer (
  // Clock and reset
  input  wire  logic              mclk,
  input  wire  logic              sys_rst,
  // Timebase pin, 32768 Hz
  input  wire  logic              timebaseClk,
  // Configuration register port
  input  wire  logic [15:0]       ioAddr,
  input  wire  logic              ioWrEn,
  input  wire  logic [7:0]        ioWrData,
  input  wire  logic              ioRdEn,
  output logic [7:0]              ioRdData,
  // Sequencer and front-end controls
  output ams_pkg::ams_seq_s       seqOut,
  output ams_pkg::ams_cfg_s       cfgOut
);

  // ----------------------------------------------------------------------
  // Decoding helpers
  // ----------------------------------------------------------------------

  // Maps an address to its storage index
  function automatic logic [3:0] regIndex(input logic [15:0] a);
    case (a)
      ams_pkg::AMS_ADDR_FRAME_S10: regIndex = 4'h0;
      ams_pkg::AMS_ADDR_S8_S9:     regIndex = 4'h1;
      ams_pkg::AMS_ADDR_S6_S7:     regIndex = 4'h2;
      ams_pkg::AMS_ADDR_S4_S5:     regIndex = 4'h3;
      ams_pkg::AMS_ADDR_S2_S3:     regIndex = 4'h4;
      ams_pkg::AMS_ADDR_S0_S1:     regIndex = 4'h5;
      ams_pkg::AMS_ADDR_EQU_CHOP:  regIndex = ams_pkg::AMS_IDX_EQU_CHOP;
      ams_pkg::AMS_ADDR_FILT_DIFF: regIndex = ams_pkg::AMS_IDX_FILT_DIFF;
      ams_pkg::AMS_ADDR_CONV_CLK:  regIndex = ams_pkg::AMS_IDX_CONV_CLK;
      ams_pkg::AMS_ADDR_PREAMP:    regIndex = ams_pkg::AMS_IDX_PREAMP;
      ams_pkg::AMS_ADDR_REMOTE:    regIndex = ams_pkg::AMS_IDX_REMOTE;
      default:                     regIndex = ams_pkg::AMS_IDX_NONE;
    endcase
  endfunction

  // Slot n lives in byte 5 - n/2, low nibble for even n
  function automatic logic [3:0] slotHandle(input logic [7:0] b0,
      input logic [7:0] b1, input logic [3:0] n);
    slotHandle = n[0] ? b1[7:4] : b0[3:0];
  endfunction

  // ----------------------------------------------------------------------
  // Configuration registers
  // ----------------------------------------------------------------------
  logic [7:0] regQ [ams_pkg::AMS_NUM_REGS]; // Stored register bytes
  logic [7:0] regD [ams_pkg::AMS_NUM_REGS];
  logic [7:0] rdQ;                          // Read answer
  logic [7:0] rdD;
  logic [3:0] accIdx;                       // Index of current access

  // Next register contents and read answer
  always_comb begin
    accIdx = regIndex(ioAddr);
    regD   = regQ;
    rdD    = rdQ;
    if (ioWrEn && accIdx != ams_pkg::AMS_IDX_NONE) begin
      regD[accIdx] = ioWrData;
    end
    if (ioRdEn) begin
      // Unmapped addresses read as zero
      rdD = (accIdx == ams_pkg::AMS_IDX_NONE) ? 8'h00 : regQ[accIdx];
    end
  end

  // Register storage, cleared by reset
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      for (int i = 0; i < ams_pkg::AMS_NUM_REGS; i++) begin
        regQ[i] <= ams_pkg::AMS_REG_RESET;
      end
      rdQ <= 8'h00;
    end else begin
      regQ <= regD;
      rdQ  <= rdD;
    end
  end

  assign ioRdData = rdQ;

  // ----------------------------------------------------------------------
  // Field decode
  // ----------------------------------------------------------------------
  logic [3:0] frameCnt; // Frame slot count, clamped to the maximum
  logic [1:0] filtLen;  // Filter length
  logic       adcDiv;   // Converter rate divide
  logic       pllFast;  // Fast PLL
  logic [1:0] chopCtl;  // Reference chop control
  logic [4:0] baseDur;  // Product without the slow factor
  logic [4:0] slotDur;  // Slot duration in timebase cycles
  logic [4:0] preDur;   // Frame overhead in timebase cycles

  // Duration arithmetic from the governing fields
  always_comb begin
    frameCnt = regQ[0][ams_pkg::AMS_FRAME_CNT_LSB +: 4];
    if (frameCnt > ams_pkg::AMS_MAX_SLOTS) begin
      frameCnt = ams_pkg::AMS_MAX_SLOTS;
    end
    filtLen = regQ[ams_pkg::AMS_IDX_FILT_DIFF][ams_pkg::AMS_FILT_LSB +: 2];
    adcDiv  = regQ[ams_pkg::AMS_IDX_CONV_CLK][ams_pkg::AMS_ADC_DIV_BIT];
    pllFast = regQ[ams_pkg::AMS_IDX_CONV_CLK][ams_pkg::AMS_PLL_FAST_BIT];
    chopCtl = regQ[ams_pkg::AMS_IDX_EQU_CHOP][ams_pkg::AMS_CHOP_LSB +: 2];
    baseDur = {3'b000, filtLen} + 5'd1;
    if (adcDiv) begin
      baseDur = {baseDur[3:0], 1'b0};
    end
    slotDur = pllFast ? baseDur
                      : 5'(baseDur + {baseDur[3:0], 1'b0});
    preDur  = pllFast ? ams_pkg::AMS_PRE_FAST : ams_pkg::AMS_PRE_SLOW;
  end

  // ----------------------------------------------------------------------
  // Timebase edge detection
  // ----------------------------------------------------------------------
  logic [2:0] tbSyncQ;  // Three-stage synchroniser, bit 0 first
  logic [2:0] tbSyncD;
  logic       tbLevelQ; // Accepted timebase level
  logic       tbLevelD;
  logic       tick;     // One cycle per accepted rising edge

  // Level is accepted once the second and third stages agree
  always_comb begin
    tbSyncD  = {tbSyncQ[1:0], timebaseClk};
    tbLevelD = tbLevelQ;
    tick     = 1'b0;
    if (tbSyncQ[1] == tbSyncQ[2]) begin
      tbLevelD = tbSyncQ[2];
      tick     = tbSyncQ[2] && !tbLevelQ;
    end
  end

  // Synchroniser and accepted level
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      tbSyncQ  <= 3'b000;
      tbLevelQ <= 1'b0;
    end else begin
      tbSyncQ  <= tbSyncD;
      tbLevelQ <= tbLevelD;
    end
  end

  // ----------------------------------------------------------------------
  // Frame state machine
  // ----------------------------------------------------------------------
  ams_pkg::ams_state_e stateQ; // Frame phase
  ams_pkg::ams_state_e stateD;
  logic [3:0]          slotQ;  // Slot being converted
  logic [3:0]          slotD;
  logic [4:0]          cntQ;   // Timebase cycles spent in the phase
  logic [4:0]          cntD;
  ams_pkg::ams_seq_s   seqQ;   // Registered sequencer outputs
  ams_pkg::ams_seq_s   seqD;
  ams_pkg::ams_cfg_s   cfgQ;   // Registered front-end controls
  ams_pkg::ams_cfg_s   cfgD;
  logic                frameStart; // Entering the frame overhead
  logic                slotStart;  // Entering a slot
  logic [2:0]          remoteEn;   // Remote sensor enables

  // Phase, slot and output computation
  always_comb begin
    stateD     = stateQ;
    slotD      = slotQ;
    cntD       = cntQ;
    frameStart = 1'b0;
    slotStart  = 1'b0;
    case (stateQ)
      ams_pkg::AMS_IDLE: begin
        if (tick && frameCnt != 4'd0) begin
          stateD     = ams_pkg::AMS_PRE;
          cntD       = 5'd0;
          frameStart = 1'b1;
        end
      end
      ams_pkg::AMS_PRE: begin
        if (frameCnt == 4'd0) begin
          stateD = ams_pkg::AMS_IDLE;
        end else if (tick && cntQ >= 5'(preDur - 5'd1)) begin
          stateD    = ams_pkg::AMS_SLOT;
          slotD     = 4'd0;
          cntD      = 5'd0;
          slotStart = 1'b1;
        end else if (tick) begin
          cntD = 5'(cntQ + 5'd1);
        end
      end
      ams_pkg::AMS_SLOT: begin
        if (frameCnt == 4'd0) begin
          stateD = ams_pkg::AMS_IDLE;
        end else if (tick && cntQ >= 5'(slotDur - 5'd1)) begin
          cntD = 5'd0;
          if (slotQ >= 4'(frameCnt - 4'd1)) begin
            stateD     = ams_pkg::AMS_PRE;
            frameStart = 1'b1;
          end else begin
            slotD     = 4'(slotQ + 4'd1);
            slotStart = 1'b1;
          end
        end else if (tick) begin
          cntD = 5'(cntQ + 5'd1);
        end
      end
      default: begin
        stateD = ams_pkg::AMS_IDLE;
      end
    endcase

    // Sequencer outputs
    seqD              = seqQ;
    seqD.filterStart  = slotStart;
    seqD.ceStart      = frameStart;
    // Strobe slot rounds up so it never lands in the first half
    seqD.remoteStrobe = slotStart
                        && slotD == 4'((frameCnt + 4'd1) >> 1);
    seqD.active       = stateD != ams_pkg::AMS_IDLE;
    if (slotStart) begin
      seqD.slot   = slotD;
      seqD.handle = slotHandle(regQ[5 - (slotD >> 1)],
                               regQ[5 - (slotD >> 1)], slotD);
    end
    case (chopCtl)
      ams_pkg::AMS_CHOP_HIGH: seqD.refSwap = 1'b1;
      ams_pkg::AMS_CHOP_LOW:  seqD.refSwap = 1'b0;
      default:                seqD.refSwap = seqQ.refSwap ^ frameStart;
    endcase

    // Front-end controls
    remoteEn = regQ[ams_pkg::AMS_IDX_REMOTE][ams_pkg::AMS_REMOTE_LSB +: 3];
    cfgD.remoteEn    = remoteEn;
    cfgD.diffEn      = regQ[ams_pkg::AMS_IDX_FILT_DIFF]
                           [ams_pkg::AMS_DIFF_LSB +: 4]
                       & ~{remoteEn, 1'b0};
    cfgD.preampGain8 = regQ[ams_pkg::AMS_IDX_PREAMP]
                           [ams_pkg::AMS_PREAMP_BIT];
    cfgD.equation    = regQ[ams_pkg::AMS_IDX_EQU_CHOP]
                           [ams_pkg::AMS_EQU_LSB +: 3];
  end

  // Phase registers and outputs
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      stateQ <= ams_pkg::AMS_IDLE;
      slotQ  <= 4'd0;
      cntQ   <= 5'd0;
      seqQ   <= '0;
      cfgQ   <= '0;
    end else begin
      stateQ <= stateD;
      slotQ  <= slotD;
      cntQ   <= cntD;
      seqQ   <= seqD;
      cfgQ   <= cfgD;
    end
  end

  assign seqOut = seqQ;
  assign cfgOut = cfgQ;

  // ----------------------------------------------------------------------
  // Frame length monitor for checks
  // ----------------------------------------------------------------------
  logic [8:0] frameTicksQ; // Timebase cycles since the frame began
  logic [8:0] frameTicksD;
  logic       cfgDirtyQ;   // A write happened during this frame
  logic       cfgDirtyD;
  logic [8:0] frameExp;    // Expected frame length

  // Counts ticks per frame, flags frames disturbed by writes
  always_comb begin
    frameTicksD = frameStart ? 9'd0 : 9'(frameTicksQ + {8'd0, tick});
    cfgDirtyD   = frameStart ? ioWrEn : (cfgDirtyQ || ioWrEn);
    frameExp    = 9'(9'(preDur) + 9'(slotDur) * 9'(frameCnt));
  end

  // Monitor registers
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      frameTicksQ <= 9'd0;
      cfgDirtyQ   <= 1'b1;
    end else begin
      frameTicksQ <= frameTicksD;
      cfgDirtyQ   <= cfgDirtyD;
    end
  end

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (sys_rst);

  sequence s_pre_exit;
    stateQ == ams_pkg::AMS_PRE ##1 stateQ == ams_pkg::AMS_SLOT;
  endsequence

  a_frame_length_exact: assert property (
    stateQ == ams_pkg::AMS_SLOT && frameStart && !cfgDirtyQ
      |-> 9'(frameTicksQ + 9'd1) == frameExp)
    else $error("frame length differs from expected count");
  a_frame_starts_zero: assert property (s_pre_exit |-> slotQ == 4'd0)
    else $error("frame did not start at slot 0");
  a_slot_dur_bound: assert property (
    stateQ == ams_pkg::AMS_SLOT && !$changed(slotDur) |-> cntQ < slotDur)
    else $error("slot outlasted its duration");
  a_step_on_tick: assert property (
    $changed(slotQ) && stateQ == ams_pkg::AMS_SLOT |-> $past(tick))
    else $error("slot changed without a timebase edge");
  a_filter_start_slot: assert property (
    seqOut.filterStart |-> stateQ == ams_pkg::AMS_SLOT && cntQ == 5'd0
      && seqOut.slot == slotQ)
    else $error("filter start outside slot entry");
  a_ce_pass_pulse: assert property (
    seqOut.ceStart |-> stateQ == ams_pkg::AMS_PRE ##1 !seqOut.ceStart)
    else $error("compute pass start malformed");
  a_handle_select: assert property (
    slotStart |=> seqOut.handle == $past(slotHandle(regQ[5 - (slotD >> 1)],
                                         regQ[5 - (slotD >> 1)], slotD)))
    else $error("multiplexer handle does not follow slot select");
  a_remote_late_half: assert property (
    seqOut.remoteStrobe |-> {seqOut.slot, 1'b0} >= {1'b0, frameCnt})
    else $error("remote sample taken in first half");
  a_zero_suspends: assert property (
    frameCnt == 4'd0 |=> stateQ == ams_pkg::AMS_IDLE ##1 !seqOut.filterStart)
    else $error("zero count did not suspend frames");
  a_remote_diff_mask: assert property (
    remoteEn[0] |=> !cfgOut.diffEn[1])
    else $error("differential enable active on remote channel");
  a_preamp_unity: assert property (
    !regQ[ams_pkg::AMS_IDX_PREAMP][ams_pkg::AMS_PREAMP_BIT]
      |=> !cfgOut.preampGain8)
    else $error("preamp gain set while enable clear");
  a_reset_clear: assert property (
    $past(sys_rst) |-> regQ[0] == 8'h00 && regQ[7] == 8'h00)
    else $error("registers not cleared by reset");

endmodule

// [tb/ams_timebase_model.sv]
/*
  Partner model: the free-running timebase clock that paces the sequencer.
  Assumes the bench picks the half period; 15259 ns gives 32768 Hz.
*/
`timescale 1ns/1ns

module ams_timebase_model #(
  parameter int HALF_NS = 15259 // Half period in ns
) (
  // Timebase pin
  output logic timebaseClk
);
  // Runs free; the odd offset shifts its edges off the mclk edges
  initial begin
    timebaseClk = 1'b0;
    #7;
    forever #HALF_NS timebaseClk = ~timebaseClk;
  end
endmodule

// [tb/tb_adc_input_mux_sequencer.sv]
/*
  Self-checking bench for the slot sequencer: register reset and access,
  frame timing, slot handles, pulses and the configuration outputs.
  Assumes ams_pkg and the timebase model are compiled first.
*/
`timescale 1ns/1ns

module tb_adc_input_mux_sequencer;
  // ----------------------------------------------------------------------
  // Signals and case table
  // ----------------------------------------------------------------------
  typedef struct {
    logic [7:0] r [11]; // Register bytes, in the order of addrs
    int         frame;  // Expected frame length in ticks
  } ams_tbrow_s;
  logic              mclk = 1'b0;  // 25 MHz system clock
  logic              sysRst = 1'b1; // Synchronous reset
  logic              timebaseClk;  // From the partner model
  logic [15:0]       ioAddr = 16'h0000;
  logic              ioWrEn = 1'b0;
  logic [7:0]        ioWrData = 8'h00;
  logic              ioRdEn = 1'b0;
  logic [7:0]        ioRdData;
  ams_pkg::ams_seq_s seqOut;
  ams_pkg::ams_cfg_s cfgOut;
  int                tickCnt = 0;  // Timebase rising edges seen
  int                errorCnt = 0;
  int                testsRun = 0;
  ams_tbrow_s        rows [4];
  logic [15:0]       addrs [11] = '{ams_pkg::AMS_ADDR_FRAME_S10,
    ams_pkg::AMS_ADDR_S8_S9, ams_pkg::AMS_ADDR_S6_S7,
    ams_pkg::AMS_ADDR_S4_S5, ams_pkg::AMS_ADDR_S2_S3,
    ams_pkg::AMS_ADDR_S0_S1, ams_pkg::AMS_ADDR_EQU_CHOP,
    ams_pkg::AMS_ADDR_FILT_DIFF, ams_pkg::AMS_ADDR_CONV_CLK,
    ams_pkg::AMS_ADDR_PREAMP, ams_pkg::AMS_ADDR_REMOTE};

  always #20 mclk = ~mclk;
  // Counts ticks so frame lengths come out in timebase cycles
  always @(posedge timebaseClk) tickCnt <= tickCnt + 1;

  // Shortened timebase keeps the run brief
  ams_timebase_model #(.HALF_NS(310)) tbm (.timebaseClk(timebaseClk));

  ams_slot_sequencer uut (
    .mclk        (mclk),
    .sys_rst     (sysRst),
    .timebaseClk (timebaseClk),
    .ioAddr      (ioAddr),
    .ioWrEn      (ioWrEn),
    .ioWrData    (ioWrData),
    .ioRdEn      (ioRdEn),
    .ioRdData    (ioRdData),
    .seqOut      (seqOut),
    .cfgOut      (cfgOut)
  );

  // ----------------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------------
  task automatic stopTest;
    if (errorCnt == 0 && testsRun > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  task automatic chkVal(string nm, logic [15:0] ex, logic [15:0] got);
    testsRun++;
    if (got !== ex) begin
      errorCnt++;
      $display("[FAIL] %s exp %h got %h", nm, ex, got);
    end
  endtask

  // One read cycle, data compared half a cycle after the read edge
  task automatic chkReg(logic [15:0] a, logic [7:0] ex);
    @(negedge mclk);
    ioAddr = a;
    ioRdEn = 1'b1;
    @(negedge mclk);
    ioRdEn = 1'b0;
    testsRun++;
    if (ioRdData !== ex) begin
      errorCnt++;
      $display("[FAIL] reg %h exp %h got %h", a, ex, ioRdData);
    end
  endtask

  task automatic wrReg(logic [15:0] a, logic [7:0] d);
    @(negedge mclk);
    ioAddr = a;
    ioWrData = d;
    ioWrEn = 1'b1;
    @(negedge mclk);
    ioWrEn = 1'b0;
  endtask

  // Waits for a frame start, bounded
  task automatic waitCe;
    int i = 0;
    @(negedge mclk);
    while (seqOut.ceStart !== 1'b1) begin
      if (++i > 3000) begin
        errorCnt++;
        stopTest();
      end
      @(negedge mclk);
    end
  endtask

  // Reset pulse, then every register and seqOut must be zero
  task automatic rstChk;
    @(negedge mclk);
    sysRst = 1'b1;
    repeat (12) @(negedge mclk);
    sysRst = 1'b0;
    for (int k = 0; k < 11; k++) chkReg(addrs[k], 8'h00);
    chkVal("seqOut", 16'h0000, {3'h0, seqOut});
  endtask

  // Programs one table row, then measures one whole frame
  task automatic runRow(ams_tbrow_s w);
    int t0 = 0;
    int n = 0;
    int st = 0;
    int i = 0;
    logic sw;
    logic ex;
    logic [3:0] sel;
    wrReg(addrs[0], {4'h0, w.r[0][3:0]});
    for (int k = 1; k < 11; k++) wrReg(addrs[k], w.r[k]);
    wrReg(addrs[0], w.r[0]);
    for (int k = 0; k < 11; k++) chkReg(addrs[k], w.r[k]);
    chkVal("cfgOut", {5'h0, w.r[7][7:4] & ~{w.r[10][5:3], 1'b0},
      w.r[10][5:3], w.r[9][5], w.r[6][7:5]}, {5'h0, cfgOut});
    waitCe();
    chkVal("active", 16'h1, {15'h0, seqOut.active});
    sw = seqOut.refSwap;
    t0 = tickCnt;
    // Collect slot entries until the next frame start
    do begin
      @(negedge mclk);
      i++;
      if (seqOut.filterStart === 1'b1) begin
        sel = (n == 10) ? w.r[0][3:0] :
          (n[0] ? w.r[5 - n / 2][7:4] : w.r[5 - n / 2][3:0]);
        chkVal("slot", 16'(n), {12'h0, seqOut.slot});
        chkVal("handle", {12'h0, sel}, {12'h0, seqOut.handle});
        n++;
      end
      if (seqOut.remoteStrobe === 1'b1) st++;
    end while (seqOut.ceStart !== 1'b1 && i < 3000);
    if (i >= 3000) begin
      errorCnt++;
      stopTest();
    end
    chkVal("frame", 16'(w.frame), 16'(tickCnt - t0));
    chkVal("slots", {12'h0, w.r[0][7:4]}, 16'(n));
    chkVal("remote", 16'h1, 16'(st));
    ex = (w.r[6][3:2] == 2'b01) ? 1'b1 :
      ((w.r[6][3:2] == 2'b10) ? 1'b0 : ~sw);
    chkVal("refSwap", {15'h0, ex}, {15'h0, seqOut.refSwap});
  endtask

  // ----------------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------------
  initial begin
    int n = 0;
    // Transformer, shunt, slow clock, divided rate with full frame
    rows[0] = '{'{8'h70, 8'h00, 8'h00, 8'ha6, 8'h94, 8'h82, 8'ha0, 8'hf2,
      8'h10, 8'h00, 8'h00}, 15};
    rows[1] = '{'{8'h60, 8'h00, 8'h00, 8'ha9, 8'h81, 8'h10, 8'ha4, 8'hf2,
      8'h10, 8'h20, 8'h38}, 13};
    rows[2] = '{'{8'h20, 8'h00, 8'h00, 8'h00, 8'h00, 8'h53, 8'h48, 8'h00,
      8'h00, 8'h00, 8'h00}, 9};
    rows[3] = '{'{8'hba, 8'h98, 8'h76, 8'h54, 8'h32, 8'h10, 8'he0, 8'h50,
      8'h30, 8'h20, 8'h08}, 23};
    rstChk();
    // Unmapped write is dropped and unmapped read gives zero
    wrReg(16'h2107, 8'h5a);
    chkReg(16'h2107, 8'h00);
    for (int r = 0; r < 4; r++) runRow(rows[r]);
    // Zero count: no frame or filter start pulses and not active
    wrReg(addrs[0], 8'h00);
    repeat (100) @(negedge mclk);
    repeat (1500) begin
      @(negedge mclk);
      if ({seqOut.ceStart, seqOut.filterStart, seqOut.active} !== 3'b000)
        n++;
    end
    chkVal("idle", 16'h0, 16'(n));
    runRow(rows[0]);
    rstChk();
    stopTest();
  end
endmodule
